// ### verilog/plc_pkg.sv
package plc_pkg;

  // Register map
  localparam logic [11:0] LINK_CAPABILITY_OFFSET = 12'h04c;

  // Field positions
  localparam int SPEED_LSB    = 0;
  localparam int WIDTH_LSB    = 4;
  localparam int LOWPWR_LSB   = 10;
  localparam int FAST_EL_LSB  = 12;
  localparam int DEEP_EL_LSB  = 15;
  localparam int REFCLK_BIT   = 18;
  localparam int SDOWN_BIT    = 19;
  localparam int LACTIVE_BIT  = 20;
  localparam int BWNOTIFY_BIT = 21;
  localparam int PORT_ID_LSB  = 24;

  // Reset values
  localparam logic [3:0] SPEED_RESET    = 4'h2;
  localparam logic [5:0] WIDTH_RESET    = 6'h04;
  localparam logic [1:0] LOWPWR_RESET   = 2'h3;
  localparam logic [2:0] FAST_EL_RESET  = 3'h6;
  localparam logic [2:0] DEEP_EL_RESET  = 3'h2;
  localparam logic       REFCLK_RESET   = 1'h0;
  localparam logic       DOWNSTREAM_CAP = 1'h1;

  // Valid width codes
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam logic [5:0] WIDTH_X2 = 6'h02;
  localparam logic [5:0] WIDTH_X4 = 6'h04;
  localparam logic [5:0] WIDTH_X8 = 6'h08;

  // Writable capability fields, lock protected
  typedef struct packed {
    logic       bw_notify;
    logic       link_active;
    logic       surprise_down;
    logic       refclk_removal;
    logic [2:0] deep_exit;
    logic [2:0] fast_exit;
    logic [1:0] lowpower;
    logic [5:0] max_width;
  } plc_fields_type;

endpackage

// ### verilog/plc_link_cap.sv
`timescale 1ns/1ns
// Behaviour
// (R1) Bits 3:0 read-only speed, 1/2 codes
// (R2) Speed field resets to 0x2
// (R3) Bits 9:4 max width, reset x4
// (R4) Invalid width accepted, port uses default
// (R5) Written width kept; smaller forces narrower
// (R6) Bits 11:10 power support, reset 0x3
// (R7) Bits 14:12 fast exit latency, 0x6
// (R8) Bits 17:15 deep exit latency, 0x2
// (R9) Bit 18 refclk removal, reset 0
// (R10) Bit 19 surprise down; upstream zero
// (R11) Bit 20 link active; advertise only
// (R12) Bit 21 bandwidth notify; upstream zero
// (R13) Port number 31:24; 23:22 zero
// (R14) Locked fields writable only when unlocked
module plc_link_cap
  import plc_pkg::*;
#(
  parameter logic [7:0] PORT_NUMBER = 8'h00,
  parameter bit         UPSTREAM    = 1'b1
)(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // Register port
  input  wire logic [11:0] ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Device-level unlock
  input  wire logic        REG_UNLOCK,
  // Effective link settings
  output logic      [5:0]  LINK_WIDTH,
  output logic      [3:0]  LINK_SPEED,
  output logic             LINK_ACTIVE_STATUS_EN
);

  ////////////////////////////////////////////////////////////////
  // Decode
  plc_fields_type fld_r;
  plc_fields_type fld_nxt;
  logic [31:0]    rdata_r;
  logic [5:0]     width_r;
  wire            hit       = (ADDR == LINK_CAPABILITY_OFFSET);
  wire            wr_hit    = WR && hit;
  // (R14) Unlock gates writes
  wire            wr_ok     = wr_hit && REG_UNLOCK;
  wire logic [5:0] wr_width = WDATA[WIDTH_LSB +: 6];
  // (R4) Width code check
  wire            width_ok  = (fld_r.max_width == WIDTH_X1) ||
                              (fld_r.max_width == WIDTH_X2) ||
                              (fld_r.max_width == WIDTH_X4) ||
                              (fld_r.max_width == WIDTH_X8);
  // Downstream-only bits stay zero upstream
  wire            down_ok   = !UPSTREAM;

  ////////////////////////////////////////////////////////////////
  // Next field values
  always_comb
  begin
    fld_nxt = fld_r;
    if (wr_ok)
    begin
      // (R5) Software value stored verbatim
      fld_nxt.max_width      = wr_width;
      // (R6) Power support written
      fld_nxt.lowpower       = WDATA[LOWPWR_LSB +: 2];
      // (R7) Fast latency written
      fld_nxt.fast_exit      = WDATA[FAST_EL_LSB +: 3];
      // (R8) Deep latency written
      fld_nxt.deep_exit      = WDATA[DEEP_EL_LSB +: 3];
      // (R9) Refclk bit written
      fld_nxt.refclk_removal = WDATA[REFCLK_BIT];
      // (R10) Upstream held zero
      fld_nxt.surprise_down  = WDATA[SDOWN_BIT] & down_ok;
      // (R11) Advertised value only
      fld_nxt.link_active    = WDATA[LACTIVE_BIT] & down_ok;
      // (R12) Upstream held zero
      fld_nxt.bw_notify      = WDATA[BWNOTIFY_BIT] & down_ok;
    end
  end

  // (R2) Speed code is its reset value
  // (R13) Read image with port number
  wire logic [31:0] read_image = {PORT_NUMBER, 2'h0,
                                  fld_r.bw_notify, fld_r.link_active,
                                  fld_r.surprise_down, fld_r.refclk_removal,
                                  fld_r.deep_exit, fld_r.fast_exit,
                                  fld_r.lowpower, fld_r.max_width,
                                  SPEED_RESET};

  // (R4) Invalid code falls back to default
  wire logic [5:0] width_nxt = width_ok ? fld_r.max_width : WIDTH_RESET;

  ////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      // (R3) Width resets to x4
      fld_r.max_width      <= WIDTH_RESET;
      fld_r.lowpower       <= LOWPWR_RESET;
      fld_r.fast_exit      <= FAST_EL_RESET;
      fld_r.deep_exit      <= DEEP_EL_RESET;
      fld_r.refclk_removal <= REFCLK_RESET;
      // (R10) Port-type dependent defaults
      fld_r.surprise_down  <= DOWNSTREAM_CAP & down_ok;
      fld_r.link_active    <= DOWNSTREAM_CAP & down_ok;
      fld_r.bw_notify      <= DOWNSTREAM_CAP & down_ok;
      rdata_r              <= 32'h0000_0000;
      width_r              <= WIDTH_RESET;
    end
    else
    begin
      fld_r   <= fld_nxt;
      // Unmapped reads answer zero
      rdata_r <= (RD && hit) ? read_image : 32'h0000_0000;
      // (R5) Valid stored width drives link
      width_r <= width_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  assign RDATA      = rdata_r;
  assign LINK_WIDTH = width_r;
  // (R1) Speed fixed, read only
  assign LINK_SPEED = SPEED_RESET;
  // (R11) Status always reported
  assign LINK_ACTIVE_STATUS_EN = 1'b1;

  ////////////////////////////////////////////////////////////////
  // Checks
  a_speed_fixed: assert property (@(posedge REF_CLK) disable iff (RST) // (R1)
    RD && hit |=> RDATA[3:0] == 4'h2)
    else $error("speed field not 2");

  a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (RST) // (R13)
    RD && hit |=> RDATA[23:22] == 2'h0 && RDATA[31:24] == PORT_NUMBER)
    else $error("reserved or port id wrong");

  a_locked_hold: assert property (@(posedge REF_CLK) disable iff (RST) // (R14)
    wr_hit && !REG_UNLOCK |=> $stable(fld_r))
    else $error("locked write changed fields");

  a_width_store: assert property (@(posedge REF_CLK) disable iff (RST) // (R5)
    wr_ok |=> fld_r.max_width == $past(WDATA[9:4]))
    else $error("written width not kept");

  a_width_apply: assert property (@(posedge REF_CLK) disable iff (RST) // (R4)
    wr_ok && !(WDATA[9:4] inside {6'h01, 6'h02, 6'h04, 6'h08}) |=> ##1 LINK_WIDTH == 6'h04)
    else $error("invalid width not defaulted");

  a_width_valid: assert property (@(posedge REF_CLK) disable iff (RST) // (R5)
    wr_ok && WDATA[9:4] == 6'h01 |=> ##1 LINK_WIDTH == 6'h01)
    else $error("narrow width not applied");

  a_upstream_zero: assert property (@(posedge REF_CLK) disable iff (RST) // (R10)
    UPSTREAM |-> !fld_r.surprise_down && !fld_r.bw_notify && !fld_r.link_active)
    else $error("upstream bits not zero");

  a_status_on: assert property (@(posedge REF_CLK) disable iff (RST) // (R11)
    $rose(fld_r.link_active) || $fell(fld_r.link_active) |-> LINK_ACTIVE_STATUS_EN)
    else $error("status reporting dropped");

  a_read_quiet: assert property (@(posedge REF_CLK) disable iff (RST) // (R13)
    !RD |=> RDATA == 32'h0000_0000)
    else $error("read data outside answer cycle");

  ////////////////////////////////////////////////////////////////
  // Reset defaults, seen at the first edge after release
  a_reset_width: assert property (@(posedge REF_CLK) disable iff (RST) // (R3)
    $past(RST) |->
    fld_r.max_width == WIDTH_RESET && LINK_WIDTH == WIDTH_RESET)
    else $error("width not x4 after reset");

  a_reset_lowpower: assert property (@(posedge REF_CLK) disable iff (RST) // (R6)
    $past(RST) |->
    fld_r.lowpower == LOWPWR_RESET)
    else $error("power support default wrong");

  a_reset_fast_exit: assert property (@(posedge REF_CLK) disable iff (RST) // (R7)
    $past(RST) |->
    fld_r.fast_exit == FAST_EL_RESET)
    else $error("fast exit default wrong");

  a_reset_deep_exit: assert property (@(posedge REF_CLK) disable iff (RST) // (R8)
    $past(RST) |->
    fld_r.deep_exit == DEEP_EL_RESET)
    else $error("deep exit default wrong");

  a_reset_refclk: assert property (@(posedge REF_CLK) disable iff (RST) // (R9)
    $past(RST) |->
    fld_r.refclk_removal == REFCLK_RESET)
    else $error("refclk removal default wrong");

  a_reset_sdown: assert property (@(posedge REF_CLK) disable iff (RST) // (R10)
    $past(RST) |->
    fld_r.surprise_down == !UPSTREAM)
    else $error("surprise down default wrong");

  a_reset_lactive: assert property (@(posedge REF_CLK) disable iff (RST) // (R11)
    $past(RST) |->
    fld_r.link_active == !UPSTREAM)
    else $error("link active default wrong");

  a_reset_bwnotify: assert property (@(posedge REF_CLK) disable iff (RST) // (R12)
    $past(RST) |->
    fld_r.bw_notify == !UPSTREAM)
    else $error("bandwidth notify default wrong");

  ////////////////////////////////////////////////////////////////
  // Unlocked writes land field by field
  a_write_lowpower: assert property (@(posedge REF_CLK) disable iff (RST) // (R6)
    wr_ok |=>
    fld_r.lowpower == $past(WDATA[11:10]))
    else $error("power support write lost");

  a_write_fast: assert property (@(posedge REF_CLK) disable iff (RST) // (R7)
    wr_ok |=>
    fld_r.fast_exit == $past(WDATA[14:12]))
    else $error("fast exit write lost");

  a_write_deep: assert property (@(posedge REF_CLK) disable iff (RST) // (R8)
    wr_ok |=>
    fld_r.deep_exit == $past(WDATA[17:15]))
    else $error("deep exit write lost");

  a_write_refclk: assert property (@(posedge REF_CLK) disable iff (RST) // (R9)
    wr_ok |=>
    fld_r.refclk_removal == $past(WDATA[18]))
    else $error("refclk write lost");

  a_write_sdown: assert property (@(posedge REF_CLK) disable iff (RST) // (R10)
    wr_ok |=>
    fld_r.surprise_down == ($past(WDATA[19]) && !UPSTREAM))
    else $error("surprise down write wrong");

  a_write_lactive: assert property (@(posedge REF_CLK) disable iff (RST) // (R11)
    wr_ok |=>
    fld_r.link_active == ($past(WDATA[20]) && !UPSTREAM))
    else $error("link active write wrong");

  a_write_bwnotify: assert property (@(posedge REF_CLK) disable iff (RST) // (R12)
    wr_ok |=>
    fld_r.bw_notify == ($past(WDATA[21]) && !UPSTREAM))
    else $error("bandwidth notify write wrong");

  ////////////////////////////////////////////////////////////////
  // Read image carries each stored field
  a_read_width: assert property (@(posedge REF_CLK) disable iff (RST) // (R3)
    RD && hit |=>
    RDATA[9:4] == $past(fld_r.max_width))
    else $error("width readback wrong");

  a_read_lowpower: assert property (@(posedge REF_CLK) disable iff (RST) // (R6)
    RD && hit |=>
    RDATA[11:10] == $past(fld_r.lowpower))
    else $error("power support readback wrong");

  a_read_fast: assert property (@(posedge REF_CLK) disable iff (RST) // (R7)
    RD && hit |=>
    RDATA[14:12] == $past(fld_r.fast_exit))
    else $error("fast exit readback wrong");

  a_read_deep: assert property (@(posedge REF_CLK) disable iff (RST) // (R8)
    RD && hit |=>
    RDATA[17:15] == $past(fld_r.deep_exit))
    else $error("deep exit readback wrong");

  a_read_refclk: assert property (@(posedge REF_CLK) disable iff (RST) // (R9)
    RD && hit |=>
    RDATA[18] == $past(fld_r.refclk_removal))
    else $error("refclk readback wrong");

  a_read_sdown: assert property (@(posedge REF_CLK) disable iff (RST) // (R10)
    RD && hit |=>
    RDATA[19] == $past(fld_r.surprise_down))
    else $error("surprise down readback wrong");

  a_read_lactive: assert property (@(posedge REF_CLK) disable iff (RST) // (R11)
    RD && hit |=>
    RDATA[20] == $past(fld_r.link_active))
    else $error("link active readback wrong");

  a_read_bwnotify: assert property (@(posedge REF_CLK) disable iff (RST) // (R12)
    RD && hit |=>
    RDATA[21] == $past(fld_r.bw_notify))
    else $error("bandwidth notify readback wrong");

  ////////////////////////////////////////////////////////////////
  // Fixed values and refused accesses
  a_speed_code: assert property (@(posedge REF_CLK) disable iff (RST) // (R1)
    1'b1 |->
    LINK_SPEED inside {4'h1, 4'h2})
    else $error("speed code reserved");

  a_status_const: assert property (@(posedge REF_CLK) disable iff (RST) // (R11)
    1'b1 |->
    LINK_ACTIVE_STATUS_EN)
    else $error("status reporting off");

  a_width_hold: assert property (@(posedge REF_CLK) disable iff (RST) // (R5)
    !wr_ok |=>
    $stable(fld_r.max_width))
    else $error("stored width altered by hardware");

  a_width_legal: assert property (@(posedge REF_CLK) disable iff (RST) // (R4)
    1'b1 |->
    LINK_WIDTH inside {6'h01, 6'h02, 6'h04, 6'h08})
    else $error("link runs at reserved width");

  a_unmapped_write: assert property (@(posedge REF_CLK) disable iff (RST) // (R14)
    WR && !hit |=>
    $stable(fld_r))
    else $error("unmapped write changed fields");

  a_read_unmapped: assert property (@(posedge REF_CLK) disable iff (RST) // (R13)
    RD && !hit |=>
    RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_upstream_read: assert property (@(posedge REF_CLK) disable iff (RST) // (R10)
    RD && hit && UPSTREAM |=>
    RDATA[21:19] == 3'h0)
    else $error("upstream reads downstream bits");

  a_port_range: assert property (@(posedge REF_CLK) disable iff (RST) // (R13)
    1'b1 |->
    RDATA[31:24] <= 8'h05)
    else $error("port number out of range");

  c_unlocked_write: cover property (@(posedge REF_CLK) disable iff (RST) wr_ok);
  c_locked_write: cover property (@(posedge REF_CLK) disable iff (RST) wr_hit && !REG_UNLOCK);
  c_read: cover property (@(posedge REF_CLK) disable iff (RST) RD && hit);
  c_bad_width: cover property (@(posedge REF_CLK) disable iff (RST) wr_ok && wr_width == 6'h03);
  c_narrow_width: cover property (@(posedge REF_CLK) disable iff (RST)
    wr_ok && wr_width == 6'h01);

endmodule

// ### dv/plc_link_cap_tb.sv
`timescale 1ns/1ns
module plc_link_cap_tb;
  import plc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [11:0] addr    = 12'h000;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        unlock  = 1'b0;
  logic [31:0] rdata_dn;
  logic [31:0] rdata_up;
  logic [5:0]  width_dn;
  logic [3:0]  speed_dn;
  logic        status_dn;
  int          err_total = 0;
  int          checks    = 0;
  int          i;
  logic [5:0]  codes [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h03, 6'h00};
  logic [5:0]  effw  [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h04, 6'h04};
  always #20 ref_clk = ~ref_clk;
  // Downstream port 5 is the highest port number
  plc_link_cap #(.PORT_NUMBER(8'h05), .UPSTREAM(1'b0)) dut (
    .REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata_dn), .REG_UNLOCK(unlock), .LINK_WIDTH(width_dn),
    .LINK_SPEED(speed_dn), .LINK_ACTIVE_STATUS_EN(status_dn));
  plc_link_cap #(.PORT_NUMBER(8'h00), .UPSTREAM(1'b1)) dut_up (
    .REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata_up), .REG_UNLOCK(unlock), .LINK_WIDTH(),
    .LINK_SPEED(), .LINK_ACTIVE_STATUS_EN());
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] edn, input logic [31:0] eup);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    chk(rdata_dn, edn);
    chk(rdata_up, eup);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_image;
    rd_reg(LINK_CAPABILITY_OFFSET, 32'h05396c42, 32'h00016c42);
    @(posedge ref_clk);
    #1;
    chk(rdata_dn, 32'h0);
    chk({26'h0, width_dn}, {26'h0, WIDTH_RESET});
    chk({28'h0, speed_dn}, {28'h0, SPEED_RESET});
    chk({31'h0, status_dn}, 32'h1);
    rd_reg(12'h050, 32'h0, 32'h0);
  endtask
  task automatic t_locked;
    unlock <= 1'b0;
    wr_reg(LINK_CAPABILITY_OFFSET, 32'h0);
    rd_reg(LINK_CAPABILITY_OFFSET, 32'h05396c42, 32'h00016c42);
  endtask
  task automatic t_all_ones;
    unlock <= 1'b1;
    wr_reg(LINK_CAPABILITY_OFFSET, 32'hffffffff);
    rd_reg(LINK_CAPABILITY_OFFSET, 32'h053ffff2, 32'h0007fff2);
    chk({26'h0, width_dn}, {26'h0, WIDTH_X4});
    wr_reg(LINK_CAPABILITY_OFFSET, 32'h05396c42);
  endtask
  task automatic t_widths;
    unlock <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      wr_reg(LINK_CAPABILITY_OFFSET, 32'h05396c02 | ({26'h0, codes[i]} << 4));
      @(posedge ref_clk);
      #1;
      chk({26'h0, width_dn}, {26'h0, effw[i]});
      rd_reg(LINK_CAPABILITY_OFFSET, 32'h05396c02 | ({26'h0, codes[i]} << 4),
             32'h00016c02 | ({26'h0, codes[i]} << 4));
    end
    unlock <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Guard against a hung run
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    test_done();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset_image();
    t_locked();
    t_all_ones();
    t_widths();
    test_done();
  end
endmodule
